// *** hw/wdr_watchdog_reset_unit.sv ***
// wdr_watchdog_reset_unit: watchdog, time-windowed mode register, cold/warm
// flag and low-voltage reset of an 8-bit controller
// assumes single-cycle register strobes on mclk; crystal and low-voltage
// inputs are asynchronous pins; processor status inputs are on mclk
// Operation
// - stop entry sets warm flag; resets clear it
// - watchdog terminal count resets the device
// - refresh instruction starts, then restarts watchdog
// - refresh instruction updates zero, sign, overflow flags
// - mode register writable only first 64 cycles after reset or stop wake
// - mode register write-only, bank address 0fh
// - bits 1:0 pick the timeout period
// - timeout select defaults to code 01
// - bit 2 keeps counting during halt
// - bit 3 keeps counting during stop
// - bit 4 selects rc or crystal clock
// - permanent option runs watchdog from reset exit
// - otherwise every reset disables the watchdog
// - low supply holds global reset asserted
// - watchdog timeout triggers power-on delay timer
// - reset out of stop restarts at 000ch
`timescale 1ns/100ps
module wdr_watchdog_reset_unit #(
  parameter int          RC_CYC0          = wdr_pkg::RC_CYC0,
  parameter int          RC_CYC1          = wdr_pkg::RC_CYC1,
  parameter int          RC_CYC2          = wdr_pkg::RC_CYC2,
  parameter int          RC_CYC3          = wdr_pkg::RC_CYC3,
  parameter bit          PERM_ENABLE      = 1'b0,
  parameter logic [15:0] RUN_RESTART_ADDR = 16'h0000,
  parameter int          CW               = 24
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // processor status
  input  wire logic        wd_refresh,
  input  wire logic        halt_mode,
  input  wire logic        stop_mode,
  input  wire logic        stop_wake,
  output logic             cc_flag_wr,
  // pins
  input  wire logic        crystal_input_pin,
  input  wire logic        low_voltage_in,
  // reset and interrupt outputs
  output logic             device_reset,
  output logic             por_trigger,
  output logic      [15:0] restart_addr,
  output logic             irq
);
  localparam int HW = $clog2(wdr_pkg::RESET_HOLD_CYC);
  localparam logic [HW-1:0] HOLD_LAST = HW'(wdr_pkg::RESET_HOLD_CYC - 1);
  localparam logic [6:0]    WIN_END   = 7'(wdr_pkg::WINDOW_CYC);

  typedef struct packed {
    wdr_pkg::wdr_wd_state_t   wd;
    logic [7:0]               mode;
    logic                     warm;
    logic [6:0]               win_cnt;
    logic [HW-1:0]            hold;
    logic [wdr_pkg::EV_W-1:0] stat;
    logic [wdr_pkg::EV_W-1:0] mask;
    logic                     stop_d;
    logic [7:0]               rdata;
    logic                     flag_wr;
    logic                     por;
    logic [15:0]              raddr;
  } wdr_top_state_t;

  wdr_top_state_t           r_r;
  wdr_top_state_t           r_nxt;
  logic [wdr_pkg::EV_W-1:0] ev;
  logic                     lv_s;
  logic                     xtal_rise;
  logic                     win_open;
  logic                     wd_active;
  logic                     cnt_step;
  logic                     cnt_clear;
  logic [CW-1:0]            cnt_limit;
  logic [CW-1:0]            wd_count;
  logic                     wd_expired;

  // period in counter ticks for a select code and clock source
  function automatic logic [CW-1:0] period_of(input logic [1:0] tsel, input logic xtal);
    logic [CW-1:0] v;
    v = '0;
    case (tsel)
      2'b00:   v = xtal ? CW'(wdr_pkg::XTAL_CYC0) : CW'(RC_CYC0);
      2'b01:   v = xtal ? CW'(wdr_pkg::XTAL_CYC1) : CW'(RC_CYC1);
      2'b10:   v = xtal ? CW'(wdr_pkg::XTAL_CYC2) : CW'(RC_CYC2);
      default: v = xtal ? CW'(wdr_pkg::XTAL_CYC3) : CW'(RC_CYC3);
    endcase
    return v;
  endfunction : period_of

  wdr_pin_sync u_lv_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in (low_voltage_in),
    .level  (lv_s),
    .rise   ()
  );

  wdr_pin_sync u_xtal_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in (crystal_input_pin),
    .level  (),
    .rise   (xtal_rise)
  );

  assign win_open  = (r_r.win_cnt != WIN_END) && (r_r.wd != wdr_pkg::WD_RST);
  assign cnt_limit = period_of(r_r.mode[wdr_pkg::TSEL_LSB +: 2],
                               r_r.mode[wdr_pkg::CLK_XTAL_BIT]);
  // halt and stop suspend counting unless their mode bit says run
  assign wd_active = !(halt_mode && !r_r.mode[wdr_pkg::HALT_RUN_BIT]) &&
                     !(stop_mode && !r_r.mode[wdr_pkg::STOP_RUN_BIT]);
  // the rc chain is modelled by mclk; the crystal ticks on its synced
  // edges, so a crystal-clocked watchdog simply freezes when it stops
  assign cnt_step  = (r_r.wd == wdr_pkg::WD_RUN) && wd_active &&
                     (r_r.mode[wdr_pkg::CLK_XTAL_BIT] ? xtal_rise : 1'b1);
  assign cnt_clear = wd_refresh || (r_r.wd != wdr_pkg::WD_RUN);

  wdr_wdog_counter #(
    .CW (CW)
  ) u_counter (
    .mclk    (mclk),
    .resetn  (resetn),
    .clear   (cnt_clear),
    .step    (cnt_step),
    .limit   (cnt_limit),
    .count   (wd_count),
    .expired (wd_expired)
  );

  always_comb begin
    r_nxt         = r_r;
    ev            = '0;
    r_nxt.rdata   = 8'h00;
    r_nxt.flag_wr = 1'b0;
    r_nxt.por     = 1'b0;
    r_nxt.stop_d  = stop_mode;

    if (reg_wr) begin
      if (reg_addr == wdr_pkg::ADDR_WD_MODE) begin
        if (win_open) begin
          r_nxt.mode = reg_wdata & wdr_pkg::WD_MODE_WMASK;
        end else begin
          ev[wdr_pkg::EV_LOCKED] = 1'b1;
        end
      end else if (reg_addr == wdr_pkg::ADDR_IRQ_STAT) begin
        r_nxt.stat = r_r.stat & ~reg_wdata[wdr_pkg::EV_W-1:0];
      end else if (reg_addr == wdr_pkg::ADDR_IRQ_MASK) begin
        r_nxt.mask = reg_wdata[wdr_pkg::EV_W-1:0];
      end
    end

    if (reg_rd) begin
      if (reg_addr == wdr_pkg::ADDR_WD_MODE) begin
        r_nxt.rdata = 8'h00;
      end else if (reg_addr == wdr_pkg::ADDR_STOP_REC) begin
        r_nxt.rdata = {r_r.warm, 7'h00};
      end else if (reg_addr == wdr_pkg::ADDR_IRQ_STAT) begin
        r_nxt.rdata = {5'h00, r_r.stat};
      end else if (reg_addr == wdr_pkg::ADDR_IRQ_MASK) begin
        r_nxt.rdata = {5'h00, r_r.mask};
      end else if (reg_addr == wdr_pkg::ADDR_WD_STATUS) begin
        r_nxt.rdata = {5'h00, win_open, r_r.wd};
      end
    end

    if (stop_mode && !r_r.stop_d) begin
      r_nxt.warm = 1'b1;
    end

    if (r_r.win_cnt != WIN_END) begin
      r_nxt.win_cnt = r_r.win_cnt + 7'h01;
    end

    case (r_r.wd)
      wdr_pkg::WD_OFF: begin
        if (wd_refresh) begin
          r_nxt.wd      = wdr_pkg::WD_RUN;
          r_nxt.flag_wr = 1'b1;
        end
      end
      wdr_pkg::WD_RUN: begin
        if (wd_refresh) begin
          r_nxt.flag_wr = 1'b1;
        end
        if (wd_expired) begin
          r_nxt.wd   = wdr_pkg::WD_RST;
          r_nxt.hold = HOLD_LAST;
          r_nxt.por  = 1'b1;
          r_nxt.warm = 1'b0;
          r_nxt.raddr = stop_mode ? wdr_pkg::STOP_RESTART_ADDR : RUN_RESTART_ADDR;
          ev[wdr_pkg::EV_TIMEOUT] = 1'b1;
        end
      end
      wdr_pkg::WD_RST: begin
        // the device sits in reset: defaults return, the window rearms
        r_nxt.mode    = wdr_pkg::WD_MODE_RESET;
        r_nxt.win_cnt = 7'h00;
        if (r_r.hold != '0) begin
          r_nxt.hold = r_r.hold - HW'(1);
        end else begin
          r_nxt.wd = PERM_ENABLE ? wdr_pkg::WD_RUN : wdr_pkg::WD_OFF;
        end
      end
      default: begin
        r_nxt.wd = wdr_pkg::WD_OFF;
      end
    endcase

    // low supply overrides the watchdog state and stop wake, and keeps reloading the hold
    if (lv_s) begin
      if (r_r.wd != wdr_pkg::WD_RST) begin
        ev[wdr_pkg::EV_LOWVOLT] = 1'b1;
        r_nxt.warm  = 1'b0;
        r_nxt.raddr = stop_mode ? wdr_pkg::STOP_RESTART_ADDR : RUN_RESTART_ADDR;
      end
      r_nxt.wd   = wdr_pkg::WD_RST;
      r_nxt.hold = HOLD_LAST;
    end else if (stop_wake && stop_mode && r_r.wd != wdr_pkg::WD_RST) begin
      r_nxt.win_cnt = 7'h00;
      r_nxt.raddr   = wdr_pkg::STOP_RESTART_ADDR;
    end

    // a new event wins over a clear in the same cycle
    r_nxt.stat = r_nxt.stat | ev;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_r         <= '0;
      r_r.wd      <= PERM_ENABLE ? wdr_pkg::WD_RUN : wdr_pkg::WD_OFF;
      r_r.mode    <= wdr_pkg::WD_MODE_RESET;
      r_r.raddr   <= RUN_RESTART_ADDR;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata    = r_r.rdata;
  assign cc_flag_wr   = r_r.flag_wr;
  assign device_reset = (r_r.wd == wdr_pkg::WD_RST);
  assign por_trigger  = r_r.por;
  assign restart_addr = r_r.raddr;
  assign irq          = |(r_r.stat & r_r.mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_warm_on_stop;
    $rose(stop_mode) && !lv_s && !wd_expired |=> r_r.warm;
  endproperty
  a_warm_on_stop: assert property (p_warm_on_stop)
    else $error("warm flag not set on stop entry");

  property p_timeout_reset;
    wd_expired && r_r.wd == wdr_pkg::WD_RUN |=> device_reset && !r_r.warm && por_trigger;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("timeout did not reset device");

  property p_start;
    r_r.wd == wdr_pkg::WD_OFF && wd_refresh && !lv_s |=> r_r.wd == wdr_pkg::WD_RUN;
  endproperty
  a_start: assert property (p_start)
    else $error("refresh did not start watchdog");

  property p_flags;
    wd_refresh && r_r.wd != wdr_pkg::WD_RST |=> cc_flag_wr;
  endproperty
  a_flags: assert property (p_flags)
    else $error("refresh did not update condition flags");

  property p_locked;
    reg_wr && reg_addr == wdr_pkg::ADDR_WD_MODE && !win_open && !lv_s
      |=> r_r.mode == $past(r_r.mode) && r_r.stat[wdr_pkg::EV_LOCKED];
  endproperty
  a_locked: assert property (p_locked)
    else $error("mode register changed after window");

  property p_mode_read;
    reg_rd && reg_addr == wdr_pkg::ADDR_WD_MODE |=> reg_rdata == 8'h00;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode register returned data");

  property p_default;
    device_reset && !lv_s |=> r_r.mode == wdr_pkg::WD_MODE_RESET;
  endproperty
  a_default: assert property (p_default)
    else $error("mode not at default after reset");

  property p_suspend;
    (halt_mode && !r_r.mode[wdr_pkg::HALT_RUN_BIT]) ||
      (stop_mode && !r_r.mode[wdr_pkg::STOP_RUN_BIT]) |-> !cnt_step;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("watchdog counted while suspended");

  property p_xtal_clock;
    r_r.mode[wdr_pkg::CLK_XTAL_BIT] && !xtal_rise |-> !cnt_step;
  endproperty
  a_xtal_clock: assert property (p_xtal_clock)
    else $error("crystal watchdog stepped without crystal edge");

  property p_lowvolt;
    lv_s |=> device_reset [*2];
  endproperty
  a_lowvolt: assert property (p_lowvolt)
    else $error("low supply did not hold reset");

  property p_refresh_clear;
    wd_refresh && r_r.wd == wdr_pkg::WD_RUN |=> wd_count == '0;
  endproperty
  a_refresh_clear: assert property (p_refresh_clear)
    else $error("refresh did not clear counter");

  property p_stop_vector;
    wd_expired && r_r.wd == wdr_pkg::WD_RUN && stop_mode
      |=> restart_addr == wdr_pkg::STOP_RESTART_ADDR;
  endproperty
  a_stop_vector: assert property (p_stop_vector)
    else $error("stop exit vector wrong");

  c_timeout: cover property (wd_expired ##1 device_reset);
  c_lock_refused: cover property (reg_wr && reg_addr == wdr_pkg::ADDR_WD_MODE && !win_open);
  c_warm_wake: cover property (stop_mode && stop_wake && r_r.warm);
  c_irq: cover property ($rose(irq));
endmodule : wdr_watchdog_reset_unit

// *** hw/wdr_pkg.sv ***
// wdr_pkg: register map, field layout, reset values and timing counts
// of the watchdog and reset unit; assumes mclk at 125 MHz
package wdr_pkg;
  // register offsets, one byte register per address
  localparam logic [7:0] ADDR_STOP_REC  = 8'h0b;
  localparam logic [7:0] ADDR_WD_MODE   = 8'h0f;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h11;
  localparam logic [7:0] ADDR_WD_STATUS = 8'h12;

  // watchdog_mode_control fields
  localparam int TSEL_LSB      = 0;
  localparam int HALT_RUN_BIT  = 2;
  localparam int STOP_RUN_BIT  = 3;
  localparam int CLK_XTAL_BIT  = 4;
  localparam logic [7:0] WD_MODE_WMASK = 8'h1f;
  localparam logic [7:0] WD_MODE_RESET = 8'h0d;

  // stop_recovery_control cold/warm flag
  localparam int WARM_BIT = 7;

  // interrupt status / mask layout
  localparam int EV_TIMEOUT = 0;
  localparam int EV_LOWVOLT = 1;
  localparam int EV_LOCKED  = 2;
  localparam int EV_W       = 3;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RC_MIN_MS0    = 5;
  localparam int RC_MIN_MS1    = 15;
  localparam int RC_MIN_MS2    = 25;
  localparam int RC_MIN_MS3    = 100;
  localparam int RC_CYC0 = (RC_MIN_MS0 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC1 = (RC_MIN_MS1 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC2 = (RC_MIN_MS2 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC3 = (RC_MIN_MS3 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTAL_CYC0 = 256;
  localparam int XTAL_CYC1 = 512;
  localparam int XTAL_CYC2 = 1024;
  localparam int XTAL_CYC3 = 4096;
  localparam int WINDOW_CYC     = 64;
  localparam int RESET_HOLD_CYC = 16;
  localparam logic [15:0] STOP_RESTART_ADDR = 16'h000c;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_RUN = 2'b01,
    WD_RST = 2'b10
  } wdr_wd_state_t;
endpackage : wdr_pkg

// *** hw/wdr_pin_sync.sv ***
// wdr_pin_sync: two-stage synchroniser for a pin, with level and rising edge
// assumes the pin is asynchronous to mclk and slower than half its rate
`timescale 1ns/100ps
module wdr_pin_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // pin side
  input  wire logic pin_in,
  // mclk side
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wdr_sync_state_t;

  wdr_sync_state_t r_r;
  wdr_sync_state_t r_nxt;

  // s1 feeds only s2; the edge is taken between s2 and s3
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = pin_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign level = r_r.s2;
  assign rise  = r_r.s2 & ~r_r.s3;
endmodule : wdr_pin_sync

// *** hw/wdr_wdog_counter.sv ***
// wdr_wdog_counter: retriggerable count to a terminal value, pulsing expired and wrapping to zero
// assumes limit is stable while counting and at least 1
`timescale 1ns/100ps
module wdr_wdog_counter #(
  parameter int CW = 24
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // control
  input  wire logic          clear,
  input  wire logic          step,
  input  wire logic [CW-1:0] limit,
  // result
  output logic [CW-1:0]      count,
  output logic               expired
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          exp;
  } wdr_cnt_state_t;

  wdr_cnt_state_t r_r;
  wdr_cnt_state_t r_nxt;

  // clear beats step so a refresh always buys a full period
  always_comb begin
    r_nxt     = r_r;
    r_nxt.exp = 1'b0;
    if (clear) begin
      r_nxt.cnt = '0;
    end else if (step) begin
      if (r_r.cnt == limit - CW'(1)) begin
        r_nxt.cnt = '0;
        r_nxt.exp = 1'b1;
      end else begin
        r_nxt.cnt = r_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign count   = r_r.cnt;
  assign expired = r_r.exp;
endmodule : wdr_wdog_counter

// *** bench/wdr_watchdog_reset_unit_bench.sv ***
// wdr_watchdog_reset_unit_bench: self-checking bench for the watchdog and reset unit
// assumes shortened rc periods (40/60/80/100 mclk) and a free-running crystal pin
`timescale 1ns/100ps
module wdr_watchdog_reset_unit_bench;
  localparam int N0 = 40;
  localparam int N3 = 100;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        wd_refresh = 1'b0;
  logic        halt_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        stop_wake = 1'b0;
  logic        cc_flag_wr;
  logic        xtal = 1'b0;
  logic        low_voltage_in = 1'b0;
  logic        device_reset;
  logic        por_trigger;
  logic [15:0] restart_addr;
  logic        irq;
  logic [7:0]  rd_v;
  logic [7:0]  perm_rdata;
  int          ref_edges = 0;
  int          bad_count = 0;
  int          checks = 0;
  int          xtal_edges = 0;
  int          xtal_half = 20;
  int          cyc = 0;
  int          ref_cyc = 0;
  int          n;
  // expected periods: rc in mclk cycles, crystal in crystal edges
  int          rc_tab[4] = '{40, 60, 80, 100};
  int          xt_tab[4] = '{256, 512, 1024, 4096};

  wdr_watchdog_reset_unit #(.RC_CYC0(40), .RC_CYC1(60), .RC_CYC2(80), .RC_CYC3(100),
    .PERM_ENABLE(1'b0)) u_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wd_refresh(wd_refresh),
    .halt_mode(halt_mode), .stop_mode(stop_mode), .stop_wake(stop_wake),
    .cc_flag_wr(cc_flag_wr), .crystal_input_pin(xtal), .low_voltage_in(low_voltage_in),
    .device_reset(device_reset), .por_trigger(por_trigger), .restart_addr(restart_addr),
    .irq(irq));

  // factory option variant: default periods never expire within this run
  wdr_watchdog_reset_unit #(.PERM_ENABLE(1'b1)) u_dut_perm (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(perm_rdata), .wd_refresh(wd_refresh),
    .halt_mode(halt_mode), .stop_mode(stop_mode), .stop_wake(stop_wake),
    .cc_flag_wr(), .crystal_input_pin(xtal), .low_voltage_in(low_voltage_in),
    .device_reset(), .por_trigger(), .restart_addr(), .irq());

  always #4 mclk = ~mclk;
  // crystal half period is drawn from 17 to 22 ns; except at 20 it is not a multiple of the mclk half period, so phases drift
  always #(xtal_half) begin
    xtal = ~xtal;
    if (xtal) xtal_edges++;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd

  task automatic refresh();
    int p;
    p = 0;
    @(posedge mclk); wd_refresh <= 1'b1;
    @(posedge mclk); wd_refresh <= 1'b0;
    #1 ref_cyc = cyc;
    // crystal edges are counted from the refresh edge, not from the trip start
    ref_edges = xtal_edges;
    for (int i = 0; i < 3; i++) begin
      p += int'(cc_flag_wr);
      @(posedge mclk);
      #1;
    end
    chk(16'(p), 16'd1, "flag update pulses");
  endtask : refresh

  // after a watchdog reset: hold length, one timer trigger, flags and state
  task automatic hold();
    int c, p;
    c = 0; p = 0;
    while (device_reset === 1'b1 && c < 200) begin
      c++;
      p += int'(por_trigger);
      @(posedge mclk);
      #1;
    end
    chk(16'(c), 16'd16, "reset hold cycles");
    chk(16'(p), 16'd1, "delay timer triggers");
    rd(wdr_pkg::ADDR_IRQ_STAT); chk(rd_v, 8'h01, "timeout event");
    wr(wdr_pkg::ADDR_IRQ_STAT, 8'hff);
    rd(wdr_pkg::ADDR_STOP_REC); chk(rd_v, 8'h00, "cold after timeout");
    rd(wdr_pkg::ADDR_WD_STATUS); chk(rd_v, 8'h04, "off after reset");
  endtask : hold

  task automatic trip(input int lo, input int hi, input bit by_xtal, input bit in_stop);
    int e0, t;
    e0 = ref_edges;
    t = cyc - ref_cyc;
    while (device_reset !== 1'b1 && t < 40000) begin
      @(posedge mclk);
      #1 t = cyc - ref_cyc;
    end
    if (by_xtal) t = xtal_edges - e0;
    chk(16'(t >= lo && t <= hi), 16'd1, "timeout span");
    chk(restart_addr, in_stop ? 16'h000c : 16'h0000, "restart vector");
    hold();
  endtask : trip

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    // about twice the expected run, dominated by the crystal periods
    #600000;
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(79));
    xtal_half = 17 + $urandom % 6;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rd(wdr_pkg::ADDR_WD_STATUS); chk(rd_v, 8'h04, "off from reset");
    chk(perm_rdata, 8'h05, "permanent runs from reset");
    rd(wdr_pkg::ADDR_WD_MODE); chk(rd_v, 8'h00, "mode not readable");
    rd(wdr_pkg::ADDR_STOP_REC); chk(rd_v, 8'h00, "cold from reset");
    n = 8'h20 + $urandom % 8'hd0;
    wr(8'(n), 8'($urandom));
    rd(8'(n)); chk(rd_v, 8'h00, "unmapped read");
    $display("test reset values done");
    // every period code from both clock sources
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(wdr_pkg::ADDR_WD_MODE, 8'(s * 16 + c));
        refresh();
        if (s == 0) trip(rc_tab[c] - 1, rc_tab[c] + 3, 1'b0, 1'b0);
        else trip(xt_tab[c] - 1, xt_tab[c] + 2, 1'b1, 1'b0);
      end
    end
    $display("test period codes done");
    wr(wdr_pkg::ADDR_WD_MODE, 8'h00);
    refresh();
    rd(wdr_pkg::ADDR_WD_STATUS); chk(rd_v, 8'h05, "running after start");
    repeat (20) @(posedge mclk);
    refresh();
    trip(N0 - 1, N0 + 3, 1'b0, 1'b0);
    $display("test restart done");
    // late write is refused and the default code stays
    repeat (70) @(posedge mclk);
    wr(wdr_pkg::ADDR_WD_MODE, 8'h00);
    rd(wdr_pkg::ADDR_IRQ_STAT); chk(rd_v, 8'h04, "locked write event");
    wr(wdr_pkg::ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b1, "irq unmasked");
    wr(wdr_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0, "irq masked");
    wr(wdr_pkg::ADDR_IRQ_MASK, 8'h04);
    wr(wdr_pkg::ADDR_IRQ_STAT, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0, "irq cleared");
    wr(wdr_pkg::ADDR_IRQ_MASK, 8'h00);
    refresh();
    trip(rc_tab[1] - 1, rc_tab[1] + 3, 1'b0, 1'b0);
    $display("test window lock done");
    for (int b = 0; b < 2; b++) begin
      wr(wdr_pkg::ADDR_WD_MODE, 8'(b * 4));
      refresh();
      @(posedge mclk); halt_mode <= 1'b1;
      if (b == 0) begin
        repeat (100) @(posedge mclk);
        #1 chk(device_reset, 1'b0, "halt suspends");
        @(posedge mclk); halt_mode <= 1'b0;
        trip(N0 + 95, N0 + 110, 1'b0, 1'b0);
      end else begin
        trip(N0 - 1, N0 + 3, 1'b0, 1'b0);
      end
      @(posedge mclk); halt_mode <= 1'b0;
    end
    $display("test halt done");
    for (int b = 0; b < 2; b++) begin
      wr(wdr_pkg::ADDR_WD_MODE, 8'(b * 8));
      refresh();
      @(posedge mclk); stop_mode <= 1'b1;
      rd(wdr_pkg::ADDR_STOP_REC); chk(rd_v, 8'h80, "warm on stop entry");
      if (b == 1) begin
        trip(N0 - 1, N0 + 3, 1'b0, 1'b1);
      end else begin
        repeat (100) @(posedge mclk);
        #1 chk(device_reset, 1'b0, "stop suspends");
        @(posedge mclk); stop_wake <= 1'b1;
        @(posedge mclk); stop_wake <= 1'b0; stop_mode <= 1'b0;
        rd(wdr_pkg::ADDR_STOP_REC); chk(rd_v, 8'h80, "warm after wake");
        // wake reopens the window, so code 11 must now take effect
        wr(wdr_pkg::ADDR_WD_MODE, 8'h03);
        refresh();
        trip(N3 - 1, N3 + 3, 1'b0, 1'b0);
      end
      @(posedge mclk); stop_mode <= 1'b0;
    end
    $display("test stop done");
    @(posedge mclk); low_voltage_in <= 1'b1;
    n = 0;
    while (device_reset !== 1'b1 && n < 10) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(16'(n <= 4), 16'd1, "low supply reset");
    repeat (30) @(posedge mclk);
    #1 chk(device_reset, 1'b1, "held in low supply");
    @(posedge mclk); low_voltage_in <= 1'b0;
    n = 0;
    while (device_reset === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(16'(n >= 16 && n <= 22), 16'd1, "release after supply");
    rd(wdr_pkg::ADDR_IRQ_STAT); chk(rd_v, 8'h02, "low supply event");
    rd(wdr_pkg::ADDR_WD_STATUS); chk(rd_v, 8'h04, "off after supply reset");
    chk(perm_rdata, 8'h05, "permanent runs after reset");
    $display("test low supply done");
    results();
  end
endmodule : wdr_watchdog_reset_unit_bench
